// ==== shared/capcom_map.vh ====
// Register map, field layout and mode codes of the dual capture/compare array.
// =====================================================================
// Functional notes
// RQ1: Two units of sixteen channels each, thirty-two channels in total.
// RQ2: Each unit has two 16-bit timebases, each with its own reload register.
// RQ3: A timebase counts prescaled system clock ticks or feeder timer overflow pulses.
// RQ4: The first timebase of each unit may also count an external count input.
// RQ5: Each channel selects either unit timebase and capture or compare operation.
// RQ6: Each channel owns one pin: capture trigger input or compare event output.
// RQ7: Second unit captures on sixteen channels but drives only twelve outputs.
// RQ8: One external signal feeding both first timebases makes them count in lockstep.
// RQ9: A capture edge copies the timebase count into the channel and requests interrupt.
// RQ10: Capture trigger per channel: rising only, falling only, or both edges.
// RQ11: Compare channels are matched continuously against their timebase; mode sets action.
// RQ12: Compare mode 0 only raises the interrupt, several times per period.
// RQ13: Compare mode 1 toggles the pin on every match.
// RQ14: Compare mode 2 raises the interrupt at most once per timer period.
// RQ15: Compare mode 3 sets the pin on match, clears it on timer overflow.
// RQ16: Double-register mode: two channels toggle one shared pin on each match.
// RQ17: Input select code 000b divides by 8, each code doubles up to 1024.
// RQ18: Reload value sets the period; 0000h gives the full 16-bit range.
// RQ19: Each source sets its request flag; request forwarded only while enabled.
// RQ20: Timebases count up, reload on overflow, signal overflow to channels and flag.
// RQ21: Pins and count inputs are synchronised to the clock before edge detection.
`ifndef CAPCOM_MAP_VH
`define CAPCOM_MAP_VH

// =====================================================================
// Word indices, byte address bits 9:2.
`define IDX_CHAN_VAL 8'h00
`define IDX_CHAN_CTL 8'h20
`define IDX_TMR_CNT 8'h40
`define IDX_TMR_REL 8'h44
`define IDX_TMR_CTL 8'h48
`define IDX_END 8'h4c

// =====================================================================
// Timer control fields.
`define TC_SEL 2:0
`define TC_SRC 4:3
`define TC_RUN 5
`define TC_FLAG 6
`define TC_EN 7
`define TC_RESET 8'h00
`define SRC_PRESCALE 2'h0
`define SRC_FEEDER 2'h1
`define SRC_EXTERNAL 2'h2
`define PRESCALE_BASE 10'h3f8

// =====================================================================
// Channel control fields and modes.
`define CC_MODE 3:0
`define CC_TB 4
`define CC_FLAG 5
`define CC_EN 6
`define CC_RESET 7'h00
`define M_OFF 4'h0
`define M_CAP_RISE 4'h1
`define M_CAP_FALL 4'h2
`define M_CAP_BOTH 4'h3
`define M_CMP0 4'h4
`define M_CMP1 4'h5
`define M_CMP2 4'h6
`define M_CMP3 4'h7
`define M_DOUBLE 4'h8
`define INPUT_ONLY_MASK 32'h0f000000

`endif

// ==== verilog/capcom_array.v ====
// Dual capture/compare array with four timebases behind an AHB-Lite slave.
//
// Chosen here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "capcom_map.vh"

module capcom_array (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire [31:0] cc_pin_in,
  output reg [31:0] cc_pin_out,
  output reg [31:0] cc_pin_oe,
  input wire [1:0] ext_count_in,
  input wire feeder_timer_ovf,
  output reg [31:0] chan_irq,
  output reg [3:0] timer_irq
);

  // =====================================================================
  // Bus slave.
  reg wr_q;
  reg [7:0] widx_q;
  reg [31:0] rdata;
  wire [7:0] ridx;
  wire [511:0] val_flat;
  wire [223:0] ctl_flat;
  wire [63:0] cnt_flat;
  wire [63:0] rel_flat;
  wire [31:0] tctl_flat;

  assign ridx = haddr[9:2];

  // Read data is taken during the address phase so the data phase needs no wait state.
  always @*
  begin
    rdata = 32'h00000000;
    if (ridx < `IDX_CHAN_CTL)
      rdata[15:0] = val_flat[16*ridx[4:0] +: 16];
    else if (ridx < `IDX_TMR_CNT)
      rdata[6:0] = ctl_flat[7*ridx[4:0] +: 7];
    else if (ridx < `IDX_TMR_REL)
      rdata[15:0] = cnt_flat[16*ridx[1:0] +: 16];
    else if (ridx < `IDX_TMR_CTL)
      rdata[15:0] = rel_flat[16*ridx[1:0] +: 16];
    else if (ridx < `IDX_END)
      rdata[7:0] = tctl_flat[8*ridx[1:0] +: 8];
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q <= 1'b0;
      widx_q <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready)
      begin
        wr_q <= hsel & htrans[1] & hwrite;
        widx_q <= ridx;
        if (hsel & htrans[1] & ~hwrite)
          hrdata <= rdata;
      end
      else
        wr_q <= 1'b0;
    end
  end

  function wr_hit;
    input w;
    input [7:0] idx;
    input [31:0] target;
    begin
      wr_hit = w & ({24'h000000, idx} == target);
    end
  endfunction

  // 2**(sel+3) divider taps on a free-running counter.
  function presc_tick;
    input [9:0] c;
    input [2:0] s;
    reg [9:0] m;
    begin
      m = ~(`PRESCALE_BASE << s);
      presc_tick = ((c & m) == m);
    end
  endfunction

  // =====================================================================
  // Input synchronisers and edge detection.
  reg [31:0] pin_s1_q;
  reg [31:0] pin_s2_q;
  reg [31:0] pin_s3_q;
  reg [1:0] ext_s1_q;
  reg [1:0] ext_s2_q;
  reg [1:0] ext_s3_q;
  reg [9:0] pre_q;
  wire [31:0] pin_rise;
  wire [31:0] pin_fall;
  wire [1:0] ext_rise;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_s1_q <= 32'h00000000;
      pin_s2_q <= 32'h00000000;
      pin_s3_q <= 32'h00000000;
      ext_s1_q <= 2'h0;
      ext_s2_q <= 2'h0;
      ext_s3_q <= 2'h0;
      pre_q <= 10'h000;
    end
    else
    begin
      pin_s1_q <= cc_pin_in; // [RQ21]
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      ext_s1_q <= ext_count_in; // [RQ21]
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
      pre_q <= pre_q + 10'h001;
    end
  end

  assign pin_rise = pin_s2_q & ~pin_s3_q;
  assign pin_fall = ~pin_s2_q & pin_s3_q;
  assign ext_rise = ext_s2_q & ~ext_s3_q;

  // =====================================================================
  // Timebases: index 0,1 belong to the first unit, 2,3 to the second.
  wire [3:0] tmr_step;
  wire [3:0] tmr_ovf;

  genvar t;
  generate
    for (t = 0; t < 4; t = t + 1)
    begin : g_tmr
      reg [15:0] cnt_q;
      reg [15:0] rel_q;
      reg [7:0] ctl_q;
      reg step_q;
      reg ovf_q;
      wire inc;
      wire wr_cnt;
      assign wr_cnt = wr_hit(wr_q, widx_q, `IDX_TMR_CNT + t);
      // Only the first timebase of a unit sees an external count input.
      assign inc = ctl_q[`TC_RUN] &
        ((ctl_q[`TC_SRC] == `SRC_PRESCALE) ? presc_tick(pre_q, ctl_q[`TC_SEL]) : // [RQ17]
         (ctl_q[`TC_SRC] == `SRC_FEEDER) ? feeder_timer_ovf : // [RQ3]
         (ctl_q[`TC_SRC] == `SRC_EXTERNAL) ? ((t % 2 == 0) & ext_rise[t/2]) : // [RQ4] [RQ8]
         1'b0);
      always @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          cnt_q <= 16'h0000;
          rel_q <= 16'h0000;
          ctl_q <= `TC_RESET;
          step_q <= 1'b0;
          ovf_q <= 1'b0;
          timer_irq[t] <= 1'b0;
        end
        else
        begin
          if (wr_cnt)
            cnt_q <= hwdata[15:0];
          else if (inc)
            cnt_q <= (cnt_q == 16'hffff) ? rel_q : cnt_q + 16'h0001; // [RQ2] [RQ18] [RQ20]
          if (wr_hit(wr_q, widx_q, `IDX_TMR_REL + t))
            rel_q <= hwdata[15:0];
          if (wr_hit(wr_q, widx_q, `IDX_TMR_CTL + t))
            ctl_q <= hwdata[7:0];
          // A flag set by overflow wins over a clear in the same cycle.
          if (ovf_q)
            ctl_q[`TC_FLAG] <= 1'b1; // [RQ19] [RQ20]
          step_q <= inc & ~wr_cnt;
          ovf_q <= inc & ~wr_cnt & (cnt_q == 16'hffff);
          timer_irq[t] <= ctl_q[`TC_FLAG] & ctl_q[`TC_EN]; // [RQ19]
        end
      end
      assign tmr_step[t] = step_q;
      assign tmr_ovf[t] = ovf_q;
      assign cnt_flat[16*t +: 16] = cnt_q;
      assign rel_flat[16*t +: 16] = rel_q;
      assign tctl_flat[8*t +: 8] = ctl_q;
    end
  endgenerate

  // =====================================================================
  // Channels.
  wire [31:0] tog_self;
  wire [31:0] tog_part;
  wire [31:0] is_double;
  wire [31:0] out_mask;

  // Input-only pins are masked here once so no channel can ever enable them.
  assign out_mask = ~`INPUT_ONLY_MASK;

  genvar i;
  generate
    for (i = 0; i < 32; i = i + 1)
    begin : g_ch // [RQ1]
      reg [15:0] val_q;
      reg [6:0] ctl_q;
      reg done_q;
      wire [1:0] tb;
      wire [15:0] tcnt;
      wire [3:0] mode;
      wire match;
      wire cap_ev;
      wire once;
      wire cmp_ev;
      wire drive;
      assign mode = ctl_q[`CC_MODE];
      assign tb = {(i >= 16), ctl_q[`CC_TB]}; // [RQ5]
      assign tcnt = cnt_flat[16*tb +: 16];
      // Matching only on a fresh count keeps a stopped timer from re-firing.
      assign match = tmr_step[tb] & (tcnt == val_q); // [RQ11]
      assign cap_ev = ((mode == `M_CAP_RISE) & pin_rise[i]) |
        ((mode == `M_CAP_FALL) & pin_fall[i]) |
        ((mode == `M_CAP_BOTH) & (pin_rise[i] | pin_fall[i])); // [RQ10]
      assign once = (mode == `M_CMP2) | (mode == `M_CMP3);
      assign cmp_ev = match & (((mode == `M_CMP0) | (mode == `M_CMP1) | // [RQ12]
        (mode == `M_DOUBLE)) | (once & ~done_q)); // [RQ14] [RQ15]
      assign is_double[i] = (mode == `M_DOUBLE);
      assign tog_self[i] = cmp_ev & ((mode == `M_CMP1) | // [RQ13]
        (is_double[i] & ((i % 16) < 8))); // [RQ16]
      assign tog_part[i] = cmp_ev & is_double[i] & ((i % 16) >= 8); // [RQ16]
      assign drive = out_mask[i]; // [RQ7]
      always @(posedge hclk or negedge hresetn)
      begin
        if (!hresetn)
        begin
          val_q <= 16'h0000;
          ctl_q <= `CC_RESET;
          done_q <= 1'b0;
          cc_pin_out[i] <= 1'b0;
          cc_pin_oe[i] <= 1'b0;
          chan_irq[i] <= 1'b0;
        end
        else
        begin
          if (wr_hit(wr_q, widx_q, `IDX_CHAN_VAL + i))
            val_q <= hwdata[15:0];
          if (cap_ev)
            val_q <= tcnt; // [RQ9]
          if (wr_hit(wr_q, widx_q, `IDX_CHAN_CTL + i))
            ctl_q <= hwdata[6:0];
          if (cap_ev | cmp_ev)
            ctl_q[`CC_FLAG] <= 1'b1; // [RQ9] [RQ19]
          if (tmr_ovf[tb])
            done_q <= 1'b0;
          if (cmp_ev & once)
            done_q <= 1'b1; // [RQ14] [RQ15]
          if (mode == `M_CMP3)
          begin
            if (cmp_ev)
              cc_pin_out[i] <= drive; // [RQ15]
            else if (tmr_ovf[tb])
              cc_pin_out[i] <= 1'b0; // [RQ15]
          end
          else if (tog_self[i] | (((i % 16) < 8) & tog_part[(i + 8) % 32]))
            cc_pin_out[i] <= ~cc_pin_out[i] & drive; // [RQ6] [RQ13] [RQ16]
          cc_pin_oe[i] <= drive & ((mode == `M_CMP1) | (mode == `M_CMP3) |
            (((i % 16) < 8) & (is_double[i] | is_double[(i + 8) % 32]))); // [RQ6] [RQ7]
          chan_irq[i] <= ctl_q[`CC_FLAG] & ctl_q[`CC_EN]; // [RQ19]
        end
      end
      assign val_flat[16*i +: 16] = val_q;
      assign ctl_flat[7*i +: 7] = ctl_q;
    end
  endgenerate

endmodule

// ==== sim/capcom_array_monitor.sv ====
// Port checker for the dual capture/compare array.
`timescale 1ns/100ps
module capcom_array_monitor (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] cc_pin_out,
  input wire [31:0] cc_pin_oe,
  input wire [31:0] chan_irq,
  input wire [3:0] timer_irq
);
  // =====================================================================
  // Helper state: a write data phase, and whether any write has landed yet.
  logic wr_q;
  logic wrote_q;
  wire rd_ap = hsel & hready & htrans[1] & !hwrite;
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wr_q <= 1'b0;
      wrote_q <= 1'b0;
    end
    else
    begin
      wr_q <= hsel & hready & htrans[1] & hwrite;
      wrote_q <= wrote_q | wr_q;
    end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_input_only_oe: assert property ((cc_pin_oe & 32'h0f000000) == 32'h0)
    else $error("input-only pin enabled");
  a_input_only_out: assert property (cc_pin_out[27:24] == 4'h0)
    else $error("input-only pin output set");
  a_no_wait: assert property ($past(hresetn) |-> hreadyout)
    else $error("wait state inserted");
  a_okay_resp: assert property (hresp == 1'b0)
    else $error("error response");
  a_rdata_hold: assert property ($changed(hrdata) |-> $past(rd_ap))
    else $error("read data changed without a read");
  // Pin enables follow configuration only, so they move just after a write.
  a_oe_from_write: assert property ($changed(cc_pin_oe) |->
    $past(wr_q) || $past(wr_q, 2) || $past(wr_q, 3))
    else $error("pin enable changed without a write");
  a_irq_needs_write: assert property (!wrote_q |->
    chan_irq == 32'h0 && timer_irq == 4'h0)
    else $error("request forwarded while disabled");
  a_reset_quiet: assert property ($rose(hresetn) |->
    cc_pin_oe == 32'h0 && chan_irq == 32'h0)
    else $error("pins or requests active after reset");
  cover property (chan_irq[0]);
  cover property ($rose(cc_pin_out[0]));
  cover property (timer_irq[1]);
endmodule
bind capcom_array capcom_array_monitor i_capcom_array_monitor (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .cc_pin_out(cc_pin_out), .cc_pin_oe(cc_pin_oe),
  .chan_irq(chan_irq), .timer_irq(timer_irq));

// ==== sim/pin_partner.sv ====
// Outside world at the channel pins.
`timescale 1ns/100ps
module pin_partner (
  input wire [31:0] pin_out,
  input wire [31:0] pin_oe,
  input wire [31:0] ext_level,
  output wire [31:0] pin_level
);
  // A driven pin shows the channel level, an undriven one the outside source.
  assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

// ==== sim/testbench.sv ====
// Self-checking bench for the dual capture/compare array.
`timescale 1ns/100ps
module testbench;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic [31:0] drv;
  logic [1:0] ext;
  logic fdr;
  logic [31:0] rv;
  wire hready;
  wire hresp;
  wire [31:0] hrdata;
  wire [31:0] pin_in;
  wire [31:0] pin_out;
  wire [31:0] pin_oe;
  wire [31:0] chan_irq;
  wire [3:0] timer_irq;
  int num_errors;
  int compares;
  int cyc;
  // Rows: address, write data, read-back expected.
  logic [95:0] rows [0:4] = '{{32'h110, 32'hffff1234, 32'h1234},
    {32'h004, 32'hffffffff, 32'hffff}, {32'h0fc, 32'hffffff60, 32'h60},
    {32'h10c, 32'hbeef, 32'hbeef}, {32'h130, 32'h12345678, 32'h0}};
  capcom_array i_capcom_array (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .cc_pin_in(pin_in),
    .cc_pin_out(pin_out), .cc_pin_oe(pin_oe), .ext_count_in(ext),
    .feeder_timer_ovf(fdr), .chan_irq(chan_irq), .timer_irq(timer_irq));
  pin_partner i_pin_partner (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(drv),
    .pin_level(pin_in));
  // =====================================================================
  // Bus, comparison and closing tasks.
  task give_verdict;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    rv = hrdata;
  endtask
  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  // A hang is cut short well beyond the few hundred cycles the run needs.
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      num_errors++;
      give_verdict;
    end
  end
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    drv = 32'h0;
    ext = 2'h0;
    fdr = 1'b0;
    num_errors = 0;
    compares = 0;
    cyc = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, 32'h080, 32'h0);
    chk(rv, 32'h0);
    xfer(1'b0, 32'h120, 32'h0);
    chk(rv, 32'h0);
    foreach (rows[i])
    begin
      xfer(1'b1, rows[i][95:64], rows[i][63:32]);
      xfer(1'b0, rows[i][95:64], 32'h0);
      chk(rv, rows[i][31:0]);
    end
    xfer(1'b1, 32'h000, 32'h12);
    xfer(1'b1, 32'h080, 32'h45);
    xfer(1'b1, 32'h0e0, 32'h45);
    xfer(1'b1, 32'h100, 32'h10);
    xfer(1'b1, 32'h120, 32'h20);
    for (int k = 0; k < 200 && pin_out[0] !== 1'b1; k++) @(posedge hclk);
    chk(pin_out[0], 32'h1);
    chk(pin_oe[24], 32'h0);
    repeat (2) @(posedge hclk);
    chk(chan_irq[0], 32'h1);
    xfer(1'b1, 32'h120, 32'h0);
    xfer(1'b1, 32'h104, 32'h1234);
    for (int c = 1; c < 4; c++) xfer(1'b1, 32'h080 + 4 * c, 32'h50 + c);
    drv <= 32'he;
    repeat (8) @(posedge hclk);
    chk(chan_irq[3:1], 32'h5);
    for (int c = 1; c < 4; c++)
    begin
      xfer(1'b0, 4 * c, 32'h0);
      chk(rv, c == 2 ? 32'h0 : 32'h1234);
    end
    xfer(1'b1, 32'h104, 32'h5678);
    drv <= 32'h0;
    repeat (8) @(posedge hclk);
    for (int c = 1; c < 4; c++)
    begin
      xfer(1'b0, 4 * c, 32'h0);
      chk(rv, c == 1 ? 32'h1234 : 32'h5678);
    end
    xfer(1'b1, 32'h100, 32'h0);
    xfer(1'b1, 32'h108, 32'h0);
    xfer(1'b1, 32'h120, 32'h30);
    xfer(1'b1, 32'h128, 32'h30);
    repeat (10)
    begin
      ext <= ~ext;
      repeat (4) @(posedge hclk);
    end
    for (int t = 0; t < 3; t += 2)
    begin
      xfer(1'b0, 32'h100 + 4 * t, 32'h0);
      chk(rv, 32'h5);
    end
    xfer(1'b1, 32'h114, 32'habcd);
    xfer(1'b1, 32'h104, 32'hffff);
    xfer(1'b1, 32'h124, 32'ha8);
    for (int p = 0; p < 2; p++)
    begin
      fdr <= 1'b1;
      @(posedge hclk);
      fdr <= 1'b0;
      repeat (4) @(posedge hclk);
      xfer(1'b0, 32'h104, 32'h0);
      chk(rv, 32'habcd + p);
    end
    chk(timer_irq[1], 32'h1);
    xfer(1'b1, 32'h11c, 32'hfff0);
    xfer(1'b1, 32'h10c, 32'hfff0);
    xfer(1'b1, 32'h040, 32'hfff4);
    xfer(1'b1, 32'h0c0, 32'h57);
    xfer(1'b1, 32'h044, 32'hfff4);
    xfer(1'b1, 32'h0c4, 32'h56);
    xfer(1'b1, 32'h048, 32'hfff2);
    xfer(1'b1, 32'h0c8, 32'h58);
    xfer(1'b1, 32'h068, 32'hfff8);
    xfer(1'b1, 32'h0e8, 32'h58);
    xfer(1'b1, 32'h04c, 32'hfff6);
    xfer(1'b1, 32'h0cc, 32'h54);
    xfer(1'b1, 32'h12c, 32'h20);
    for (int k = 0; k < 200 && pin_out[16] !== 1'b1; k++) @(posedge hclk);
    chk(pin_out[16], 32'h1);
    chk(pin_out[18], 32'h1);
    chk(pin_oe[18], 32'h1);
    xfer(1'b1, 32'h10c, 32'hfff0);
    xfer(1'b1, 32'h0c4, 32'h56);
    xfer(1'b1, 32'h0cc, 32'h54);
    repeat (34) @(posedge hclk);
    chk(pin_out[18], 32'h0);
    repeat (50) @(posedge hclk);
    chk(chan_irq[19:17], 32'h6);
    chk(pin_out[18], 32'h1);
    chk(pin_out[16], 32'h1);
    for (int k = 0; k < 200 && pin_out[16] !== 1'b0; k++) @(posedge hclk);
    chk(pin_out[16], 32'h0);
    give_verdict;
  end
endmodule
